/* File: src/fsr_pkg.sv */
package fsr_pkg;

   // Command that starts the repeating two-byte status readout.
   localparam logic [7:0] FSR_OPC_READ_STATUS = 8'h05;

   // Bit positions within the first status byte.
   localparam int FSR_B1_LOCK = 7;
   localparam int FSR_B1_SEQ = 6;
   localparam int FSR_B1_FAIL = 5;
   localparam int FSR_B1_GUARD = 4;
   localparam int FSR_B1_SWP_HI = 3;
   localparam int FSR_B1_SWP_LO = 2;
   localparam int FSR_B1_WEL = 1;
   localparam int FSR_B1_BUSY = 0;

   // Bit positions within the second status byte.
   localparam int FSR_B2_RESET_ALLOW = 4;
   localparam int FSR_B2_BUSY = 0;

   // Software protection summary codes; 2'h2 is never produced.
   localparam logic [1:0] FSR_SWP_NONE = 2'h0;
   localparam logic [1:0] FSR_SWP_SOME = 2'h1;
   localparam logic [1:0] FSR_SWP_ALL = 2'h3;

   // Reset values.
   localparam logic FSR_LOCK_RST = 1'b0;
   localparam logic FSR_FAIL_RST = 1'b0;
   localparam logic [7:0] FSR_BYTE1_RST = 8'h1c;
   localparam logic [7:0] FSR_BYTE2_RST = 8'h00;

   // Bit counters: last opcode bit and last bit of the two-byte readout.
   localparam logic [2:0] FSR_OPC_LAST = 3'h7;
   localparam logic [3:0] FSR_READ_LAST = 4'hf;

   // Pin reset levels ahead of the synchroniser: select and guard idle high.
   localparam logic [3:0] FSR_PIN_RST = 4'h9;

   typedef enum logic [1:0] {
      FSR_IDLE = 2'b00,
      FSR_OPCODE = 2'b01,
      FSR_STREAM = 2'b10,
      FSR_IGNORE = 2'b11
   } fsr_mode_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic guard_n;
   } fsr_pins_t;

   typedef struct packed {
      logic busy;
      logic seq_program;
      logic write_latch;
      logic any_protected;
      logic all_protected;
      logic reset_allow;
   } fsr_core_t;

   typedef struct packed {
      logic done;
      logic failed;
      logic aborted;
   } fsr_op_t;

   typedef struct packed {
      fsr_mode_t mode;
      logic [2:0] opc_cnt;
      logic [6:0] opc_sh;
      logic [3:0] bit_idx;
      logic sck_prev;
      logic so;
      logic oe;
      logic lock;
      logic fail;
      logic [7:0] byte1;
      logic [7:0] byte2;
   } fsr_state_t;

endpackage : fsr_pkg

/* File: src/fsr_sync.sv */
`timescale 1ns/1ns
module fsr_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // The first stage feeds only the second; nothing else looks at it.
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         meta_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         meta_reg <= d_i;
         q_reg <= meta_reg;
      end
   end

   assign q_o = q_reg;

endmodule : fsr_sync

/* File: src/fsr_status.sv */
`timescale 1ns/1ns
// What this block does
// - Opcode 05h starts status output each clock
// - Two bytes repeat, wrapping to first byte
// - Every pass shows live status
// - Status read accepted at any time
// - Select release ends read, output floats
// - Bit 7 is lock, reset clears it
// - Lock blocks sector protect changes
// - Guard pin asserted: lock only sets
// - Write status changes only bit 7
// - Bit 6 shows sequential program mode
// - Bit 5 set on program/erase failure
// - Aborted operations never set failure
// - Failure flag updated after every operation
// - Bit 4 mirrors guard pin level
// - Bits 3:2 give protection summary
// - Bit 1 shows write latch
// - Bit 0 shows busy
// - Second byte bit 0 also busy
// - Second byte bit 4 reset allow
module fsr_status (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire fsr_pkg::fsr_pins_t pins_i,
   input wire fsr_pkg::fsr_core_t core_i,
   input wire fsr_pkg::fsr_op_t op_i,
   input wire logic wrsr_req_i,
   input wire logic wrsr_lock_i,
   input wire logic prot_cmd_req_i,
   output logic prot_cmd_grant_o,
   output logic spi_so_o,
   output logic spi_so_oe_o,
   output logic protect_map_lock_o,
   output logic [7:0] status_byte1_o,
   output logic [7:0] status_byte2_o
);

   fsr_pkg::fsr_pins_t pin;
   fsr_pkg::fsr_state_t state_reg;
   fsr_pkg::fsr_state_t state_next;
   logic sck_rise;
   logic sck_fall;
   logic [15:0] read_word;

   function automatic logic [1:0] fsr_swp(input logic any_p, input logic all_p);
      if (all_p) begin
         return fsr_pkg::FSR_SWP_ALL;
      end else if (any_p) begin
         return fsr_pkg::FSR_SWP_SOME;
      end
      return fsr_pkg::FSR_SWP_NONE;
   endfunction : fsr_swp

   function automatic logic [7:0] fsr_byte1(input fsr_pkg::fsr_core_t c, input logic lock,
                                            input logic fail, input logic guard_n);
      logic [7:0] b;
      b = 8'h00;
      b[fsr_pkg::FSR_B1_LOCK] = lock;
      b[fsr_pkg::FSR_B1_SEQ] = c.seq_program;
      b[fsr_pkg::FSR_B1_FAIL] = fail;
      b[fsr_pkg::FSR_B1_GUARD] = guard_n;
      b[fsr_pkg::FSR_B1_SWP_HI:fsr_pkg::FSR_B1_SWP_LO] =
         fsr_swp(c.any_protected, c.all_protected);
      b[fsr_pkg::FSR_B1_WEL] = c.write_latch;
      b[fsr_pkg::FSR_B1_BUSY] = c.busy;
      return b;
   endfunction : fsr_byte1

   function automatic logic [7:0] fsr_byte2(input fsr_pkg::fsr_core_t c);
      logic [7:0] b;
      b = 8'h00;
      b[fsr_pkg::FSR_B2_RESET_ALLOW] = c.reset_allow;
      b[fsr_pkg::FSR_B2_BUSY] = c.busy;
      return b;
   endfunction : fsr_byte2

   // Select, clock, data in and the guard pin all come from outside this clock.
   fsr_sync #(
      .W(4),
      .RST_VAL(fsr_pkg::FSR_PIN_RST)
   ) u_pin_sync (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .d_i(pins_i),
      .q_o(pin)
   );

   assign sck_rise = pin.sck && !state_reg.sck_prev;
   assign sck_fall = !pin.sck && state_reg.sck_prev;

   always_comb begin
      state_next = state_reg;
      state_next.sck_prev = pin.sck;

      // Protection map lock: only bit 7 of a status write lands anywhere.
      if (wrsr_req_i) begin
         if (!pin.guard_n) begin
            state_next.lock = state_reg.lock | wrsr_lock_i;
         end else begin
            state_next.lock = wrsr_lock_i;
         end
      end

      // The flag follows the last finished operation; an abort leaves it clear.
      if (op_i.done) begin
         state_next.fail = op_i.failed && !op_i.aborted;
      end

      // Assembled every cycle so that each pass of the readout is current.
      state_next.byte1 = fsr_byte1(core_i, state_next.lock, state_next.fail,
                                   pin.guard_n);
      state_next.byte2 = fsr_byte2(core_i);
      read_word = {state_next.byte1, state_next.byte2};

      if (pin.cs_n) begin
         state_next.mode = fsr_pkg::FSR_IDLE;
         state_next.oe = 1'b0;
         state_next.opc_cnt = 3'h0;
         state_next.bit_idx = 4'h0;
      end else begin
         case (state_reg.mode)
            fsr_pkg::FSR_IDLE, fsr_pkg::FSR_OPCODE: begin
               state_next.mode = fsr_pkg::FSR_OPCODE;
               if (sck_rise) begin
                  state_next.opc_sh = {state_reg.opc_sh[5:0], pin.si};
                  state_next.opc_cnt = 3'(state_reg.opc_cnt + 3'h1);
                  if (state_reg.opc_cnt == fsr_pkg::FSR_OPC_LAST) begin
                     // Busy does not gate this; status reads are always served.
                     if ({state_reg.opc_sh, pin.si} == fsr_pkg::FSR_OPC_READ_STATUS) begin
                        state_next.mode = fsr_pkg::FSR_STREAM;
                     end else begin
                        state_next.mode = fsr_pkg::FSR_IGNORE;
                     end
                  end
               end
            end
            fsr_pkg::FSR_STREAM: begin
               if (sck_fall) begin
                  state_next.so = read_word[fsr_pkg::FSR_READ_LAST - state_reg.bit_idx];
                  state_next.oe = 1'b1;
                  // The index wraps from 15 to 0: byte 2 bit 0 is followed by byte 1 bit 7.
                  state_next.bit_idx = 4'(state_reg.bit_idx + 4'h1);
               end
            end
            fsr_pkg::FSR_IGNORE: begin
               state_next.mode = fsr_pkg::FSR_IGNORE;
            end
            default: begin
               state_next.mode = fsr_pkg::FSR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_reg.mode <= fsr_pkg::FSR_IDLE;
         state_reg.opc_cnt <= 3'h0;
         state_reg.opc_sh <= 7'h00;
         state_reg.bit_idx <= 4'h0;
         state_reg.sck_prev <= 1'b0;
         state_reg.so <= 1'b0;
         state_reg.oe <= 1'b0;
         state_reg.lock <= fsr_pkg::FSR_LOCK_RST;
         state_reg.fail <= fsr_pkg::FSR_FAIL_RST;
         state_reg.byte1 <= fsr_pkg::FSR_BYTE1_RST;
         state_reg.byte2 <= fsr_pkg::FSR_BYTE2_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // Sector protect, unprotect and global changes are refused while locked.
   assign prot_cmd_grant_o = prot_cmd_req_i && !state_reg.lock;
   assign spi_so_o = state_reg.so;
   assign spi_so_oe_o = state_reg.oe;
   assign protect_map_lock_o = state_reg.lock;
   assign status_byte1_o = state_reg.byte1;
   assign status_byte2_o = state_reg.byte2;

   a_opcode_starts_read: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (!pin.cs_n && sck_rise && state_reg.mode == fsr_pkg::FSR_OPCODE
       && state_reg.opc_cnt == 3'h7 && {state_reg.opc_sh, pin.si} == 8'h05)
      |=> state_reg.mode == fsr_pkg::FSR_STREAM)
      else $error("read status opcode did not start the readout");

   a_readout_wraps: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (!pin.cs_n && state_reg.mode == fsr_pkg::FSR_STREAM && sck_fall
       && state_reg.bit_idx == 4'hf) |=> state_reg.bit_idx == 4'h0)
      else $error("readout did not wrap to first byte bit 7");

   a_busy_both_bytes: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (!pin.cs_n && state_reg.mode == fsr_pkg::FSR_STREAM && sck_fall
       && (state_reg.bit_idx == 4'h7 || state_reg.bit_idx == 4'hf))
      |=> spi_so_o == $past(core_i.busy) && spi_so_oe_o)
      else $error("busy bit not driven live in its slot");

   a_msb_first: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (!pin.cs_n && state_reg.mode == fsr_pkg::FSR_STREAM && sck_fall
       && state_reg.bit_idx == 4'h0) |=> spi_so_o == state_reg.lock)
      else $error("first bit out is not the lock bit");

   a_release_floats: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      pin.cs_n |=> !spi_so_oe_o && state_reg.mode == fsr_pkg::FSR_IDLE)
      else $error("output still driven after select release");

   a_lock_only_sets: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (wrsr_req_i && !pin.guard_n && state_reg.lock) |=> state_reg.lock)
      else $error("lock cleared while guard pin asserted");

   a_lock_blocks_prot: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      state_reg.lock |-> !prot_cmd_grant_o)
      else $error("protection change granted while locked");

   a_fail_tracks_op: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      op_i.done |=> state_reg.fail == ($past(op_i.failed) && !$past(op_i.aborted)))
      else $error("failure flag not updated at operation end");

   a_abort_no_fail: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (op_i.done && op_i.aborted) |=> ##1 !status_byte1_o[5])
      else $error("aborted operation set the failure flag");

   a_swp_no_reserved: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      status_byte1_o[3:2] != 2'h2)
      else $error("reserved protection summary code shown");

   // The checks below tie first-byte bits 6, 5, 4, 1 and 0 and the second byte to the inputs they report, one cycle late.
   // A stale byte here would mean a repeated readout pass shows old state.

   a_grant_when_open: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (prot_cmd_req_i && !state_reg.lock)
      |-> prot_cmd_grant_o)
      else $error("protection change refused while unlocked");

   a_lock_free_write: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (wrsr_req_i && pin.guard_n)
      |=> state_reg.lock == $past(wrsr_lock_i))
      else $error("lock not written while guard pin released");

   a_guard_mirror: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1
      |=> status_byte1_o[4] == $past(pin.guard_n))
      else $error("guard level bit does not follow the pin");

   a_busy_live: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1
      |=> status_byte1_o[0] == $past(core_i.busy))
      else $error("busy bit of first byte is stale");

   a_seq_shown: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1
      |=> status_byte1_o[6] == $past(core_i.seq_program))
      else $error("sequential program bit is stale");

   a_latch_shown: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1
      |=> status_byte1_o[1] == $past(core_i.write_latch))
      else $error("write latch bit is stale");

   a_byte2_layout: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1
      |=> status_byte2_o == {3'h0, $past(core_i.reset_allow), 3'h0, $past(core_i.busy)})
      else $error("second status byte layout wrong");

   a_ignore_no_drive: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      state_reg.mode == fsr_pkg::FSR_IGNORE
      |-> !spi_so_oe_o)
      else $error("output driven after a foreign opcode");

   a_fail_on_error: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (op_i.done && op_i.failed && !op_i.aborted)
      |=> status_byte1_o[5])
      else $error("failed operation did not set the failure bit");

   a_drive_only_read: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      spi_so_oe_o
      |-> state_reg.mode == fsr_pkg::FSR_STREAM)
      else $error("output driven outside the status readout");

endmodule : fsr_status

/* File: test/fsr_host_model.sv */
`timescale 1ns/1ns
module fsr_host_model (
   input wire logic core_clk_i,
   input wire logic spi_so_i,
   input wire logic spi_so_oe_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o
);
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
   end

   // Half of the 80 ns link period is five core cycles.
   task automatic half();
      repeat (5) @(posedge core_clk_i);
   endtask : half

   // Mode 0 frame: the clock idles low and stands still outside frames.
   // Bits are sampled just before each rise; a floating line reads as unknown.
   task automatic xfer(input logic [7:0] opc, input int nbits, output logic [31:0] rx);
      rx = '0;
      @(posedge core_clk_i);
      cs_n_o <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      for (int i = 7; i >= 0; i--) begin
         si_o <= opc[i];
         half();
         sck_o <= 1'b1;
         half();
         sck_o <= 1'b0;
      end
      for (int i = 0; i < nbits; i++) begin
         si_o <= ~si_o;
         half();
         rx = {rx[30:0], (spi_so_oe_i === 1'b1) ? spi_so_i : 1'bx};
         sck_o <= 1'b1;
         half();
         sck_o <= 1'b0;
      end
      half();
      cs_n_o <= 1'b1;
   endtask : xfer
endmodule : fsr_host_model

/* File: test/tb_flash_status_readout.sv */
`timescale 1ns/1ns
module tb_flash_status_readout;
   logic core_clk_i = 1'b0;
   logic rst_n_i;
   logic cs_n, sck, si, guard_n, wrsr_req, wrsr_lock, prot_req;
   fsr_pkg::fsr_pins_t pins;
   fsr_pkg::fsr_core_t core;
   fsr_pkg::fsr_op_t op;
   logic grant, so, oe, lock;
   logic [7:0] b1, b2;
   logic [31:0] rx;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;

   always #4 core_clk_i = ~core_clk_i;
   assign pins = {cs_n, sck, si, guard_n};

   fsr_status dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .pins_i(pins),
      .core_i(core), .op_i(op), .wrsr_req_i(wrsr_req), .wrsr_lock_i(wrsr_lock),
      .prot_cmd_req_i(prot_req), .prot_cmd_grant_o(grant), .spi_so_o(so),
      .spi_so_oe_o(oe), .protect_map_lock_o(lock), .status_byte1_o(b1),
      .status_byte2_o(b2));

   fsr_host_model host_u (.core_clk_i(core_clk_i), .spi_so_i(so), .spi_so_oe_i(oe),
      .cs_n_o(cs_n), .sck_o(sck), .si_o(si));

   function automatic logic [7:0] exp_b1(input logic lk, input logic fl, input logic gn);
      return {lk, core.seq_program, fl, gn,
         core.all_protected ? 2'h3 : {1'b0, core.any_protected}, core.write_latch, core.busy};
   endfunction : exp_b1

   function automatic logic [7:0] exp_b2();
      return {3'h0, core.reset_allow, 3'h0, core.busy};
   endfunction : exp_b2

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask : settle

   task automatic wrsr(input logic d);
      @(posedge core_clk_i);
      wrsr_req <= 1'b1;
      wrsr_lock <= d;
      @(posedge core_clk_i);
      wrsr_req <= 1'b0;
      settle(2);
   endtask : wrsr

   task automatic op_end(input logic f, input logic a);
      @(posedge core_clk_i);
      op <= {1'b1, f, a};
      @(posedge core_clk_i);
      op <= '0;
      settle(2);
   endtask : op_end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   // The whole run needs about a thousand cycles; this ceiling cuts a hang short.
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end

   initial begin
      rst_n_i = 1'b0;
      guard_n = 1'b1;
      core = '0;
      op = '0;
      wrsr_req = 1'b0;
      wrsr_lock = 1'b0;
      prot_req = 1'b0;
      settle(19);
      check("reset byte1", 32'h1c, b1);
      check("reset byte2", 32'h0, b2);
      check("reset enable", 32'h0, oe);
      @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      core <= 6'h3d; // Busy, sequential, latch, some protected, reset allowed.
      settle(3);
      check("live byte2", {24'h0, exp_b2()}, b2);
      host_u.xfer(8'h05, 20, rx);
      check("readout wrap", {12'h0, exp_b1(0, 0, 1), exp_b2(), 4'(exp_b1(0, 0, 1) >> 4)}, rx);
      settle(5);
      check("released", 32'h0, oe);
      fork
         host_u.xfer(8'h05, 32, rx);
         begin
            repeat (150) @(posedge core_clk_i);
            core <= 6'h06; // Ready, all sectors protected.
         end
      join
      check("second pass", {16'h0, exp_b1(0, 0, 1), exp_b2()}, {16'h0, rx[15:0]});
      host_u.xfer(8'h05, 3, rx);
      check("partial byte", {29'h0, 3'(exp_b1(0, 0, 1) >> 5)}, rx);
      settle(5);
      check("mid byte release", 32'h0, oe);
      host_u.xfer(8'h06, 4, rx);
      check("other opcode", {28'h0, 4'hx}, rx);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk_i);
         core <= {3'h0, i[1:0], 1'b0};
         settle(1);
         check("protect summary", {24'h0, exp_b1(0, 0, 1)}, b1);
      end
      @(posedge core_clk_i);
      guard_n <= 1'b0;
      prot_req <= 1'b1;
      settle(4);
      check("guard level", {24'h0, exp_b1(0, 0, 0)}, b1);
      check("grant open", 32'h1, grant);
      wrsr(1'b1);
      check("lock set", {24'h0, exp_b1(1, 0, 0)}, b1);
      check("grant shut", 32'h0, grant);
      wrsr(1'b0);
      check("lock held", 32'h1, lock);
      @(posedge core_clk_i);
      guard_n <= 1'b1;
      settle(4);
      wrsr(1'b0);
      check("lock cleared", {24'h0, exp_b1(0, 0, 1)}, b1);
      op_end(1'b1, 1'b0);
      check("fail set", 32'h1, b1[5]);
      op_end(1'b0, 1'b0);
      check("fail updated", 32'h0, b1[5]);
      op_end(1'b1, 1'b1);
      check("abort no fail", 32'h0, b1[5]);
      report_and_stop();
   end
endmodule : tb_flash_status_readout
